// file: cgo_pkg.sv
// Package for the channel gain and offset control block.
// Assumes a 32-bit Avalon-MM register bus and a byte-addressed register map.
package cgo_pkg;

   // Channel selector codes (low nibble = channel, high bits = stage)
   localparam logic [3:0] SEL_CH_ALL     = 4'h0;
   localparam logic [3:0] SEL_CH_RED     = 4'h1;
   localparam logic [3:0] SEL_CH_GREEN   = 4'h2;
   localparam logic [3:0] SEL_CH_BLUE    = 4'h3;
   localparam logic [3:0] SEL_CH_Y       = 4'h4;
   localparam logic [3:0] SEL_CH_U       = 4'h5;
   localparam logic [3:0] SEL_CH_V       = 4'h6;
   localparam logic [3:0] SEL_CH_TAP1    = 4'h7;
   localparam logic [3:0] SEL_CH_TAP2    = 4'h8;
   localparam int         NUM_CH         = 9;
   localparam logic [1:0] SEL_STG_PLAIN   = 2'h0;
   localparam logic [1:0] SEL_STG_ANALOG  = 2'h1;
   localparam logic [1:0] SEL_STG_DIGITAL = 2'h2;

   // Auto and tap-match mode codes; codes above 2 are device-specific
   localparam logic [1:0] MODE_OFF        = 2'h0;
   localparam logic [1:0] MODE_ONCE       = 2'h1;
   localparam logic [1:0] MODE_CONTINUOUS = 2'h2;
   localparam logic [1:0] MODE_HOLD       = 2'h3;

   // Register byte offsets
   localparam logic [5:0] REG_AMP_SEL         = 6'h00;
   localparam logic [5:0] REG_AMP_VALUE       = 6'h04;
   localparam logic [5:0] REG_AMP_AUTO        = 6'h08;
   localparam logic [5:0] REG_AMP_TAP_MATCH   = 6'h0C;
   localparam logic [5:0] REG_OFS_SEL         = 6'h10;
   localparam logic [5:0] REG_OFS_VALUE       = 6'h14;
   localparam logic [5:0] REG_OFS_AUTO        = 6'h18;
   localparam logic [5:0] REG_OFS_TAP_MATCH   = 6'h1C;
   localparam logic [5:0] REG_TARGET_LEVEL    = 6'h20;
   localparam logic [5:0] REG_STATUS          = 6'h24;

   // Reset values
   localparam logic [15:0] AMP_UNITY   = 16'h0100;
   localparam logic [15:0] OFS_ZERO    = 16'h0000;
   localparam logic [15:0] TARGET_RST  = 16'h0800;

   // Auto tuning: step per frame, error tolerance, frame limit for Once
   localparam logic [15:0] AMP_STEP       = 16'h0004;
   localparam logic [15:0] OFS_STEP       = 16'h0001;
   localparam logic [15:0] CONV_TOL       = 16'h0020;
   localparam logic [7:0]  ONCE_MAX_FRAMES = 8'h40;

   // Read answer delay in cycles (registered read data)
   localparam int          READ_WAIT = 1;

endpackage

// file: cgo_pixel_stage.sv
// Pixel arithmetic: offset add, then multiply by amplification, then saturate.
// Assumes amplification in 8.8 fixed point and offset as signed pixel units.
`timescale 1ns/100ps
`default_nettype none
module cgo_pixel_stage #(
   parameter int PIX_W = 12
) (
   input  wire logic               i_clock,
   input  wire logic               i_rst_n,
   input  wire logic               i_valid,
   input  wire logic [PIX_W-1:0]   i_pixel,
   input  wire logic signed [15:0] i_offset,
   input  wire logic [15:0]        i_amp,
   output logic                    o_valid,
   output logic [PIX_W-1:0]        o_pixel
);
   localparam int SUM_W = 18;
   localparam int PRD_W = SUM_W + 17;
   localparam logic [PIX_W-1:0] PIX_MAX = {PIX_W{1'b1}};

   logic signed [SUM_W-1:0] sum_reg, sum_next;
   logic                    v1_reg, v1_next;
   logic [15:0]             amp_reg, amp_next;
   logic [PIX_W-1:0]        pix_reg, pix_next;
   logic                    v2_reg, v2_next;
   logic signed [PRD_W-1:0] prod;

   always_comb begin
      sum_next = $signed({{(SUM_W-PIX_W){1'b0}}, i_pixel}) + SUM_W'(i_offset);
      v1_next  = i_valid;
      amp_next = i_amp;
      prod     = sum_reg * $signed({1'b0, amp_reg});
      v2_next  = v1_reg;
      if (prod < 0) begin
         pix_next = '0;
      end else if ((prod >>> 8) > $signed({{(PRD_W-PIX_W){1'b0}}, PIX_MAX})) begin
         pix_next = PIX_MAX;
      end else begin
         pix_next = PIX_W'(prod >>> 8);
      end
   end

   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         sum_reg <= '0;
         v1_reg  <= 1'b0;
         amp_reg <= '0;
         pix_reg <= '0;
         v2_reg  <= 1'b0;
      end else begin
         sum_reg <= sum_next;
         v1_reg  <= v1_next;
         amp_reg <= amp_next;
         pix_reg <= pix_next;
         v2_reg  <= v2_next;
      end
   end

   assign o_valid = v2_reg;
   assign o_pixel = pix_reg;
endmodule
`default_nettype wire

// file: cgo_channel_control.sv
// Channel gain and black-level control with Avalon-MM registers and pixel path.
// Assumes one pixel per cycle tagged with its channel, and a frame-end pulse.
//
// Chosen here: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module cgo_channel_control
   import cgo_pkg::*;
#(
   parameter int PIX_W = 12
) (
   input  wire logic             i_clock,
   input  wire logic             i_rst_n,
   input  wire logic [5:0]       i_address,
   input  wire logic             i_read,
   input  wire logic             i_write,
   input  wire logic [31:0]      i_writedata,
   output logic [31:0]           o_readdata,
   output logic                  o_waitrequest,
   input  wire logic             i_pix_valid,
   input  wire logic [3:0]       i_pix_channel,
   input  wire logic [PIX_W-1:0] i_pix_data,
   input  wire logic             i_frame_end,
   output logic                  o_pix_valid,
   output logic [PIX_W-1:0]      o_pix_data
);
   // Stage 0 = plain/common, 1 = analog, 2 = digital
   typedef logic [15:0] cgo_word_t;

   function automatic logic [1:0] cgo_clip_mode(input logic [31:0] d);
      cgo_clip_mode = d[1:0];
   endfunction

   cgo_word_t amp_reg   [3][NUM_CH];
   cgo_word_t amp_next  [3][NUM_CH];
   cgo_word_t ofs_reg   [NUM_CH];
   cgo_word_t ofs_next  [NUM_CH];
   logic [5:0]  amp_sel_reg, amp_sel_next;
   logic [3:0]  ofs_sel_reg, ofs_sel_next;
   logic [1:0]  amp_auto_reg [3][NUM_CH];
   logic [1:0]  amp_auto_next[3][NUM_CH];
   logic [1:0]  ofs_auto_reg [NUM_CH];
   logic [1:0]  ofs_auto_next[NUM_CH];
   logic [1:0]  amp_tm_reg, amp_tm_next;
   logic [1:0]  ofs_tm_reg, ofs_tm_next;
   cgo_word_t   target_reg, target_next;
   logic [7:0]  frames_reg, frames_next;
   logic [31:0] rdata_reg, rdata_next;
   logic        wait_reg, wait_next;
   logic [31:0] acc_reg  [NUM_CH];
   logic [31:0] acc_next [NUM_CH];
   logic [15:0] cnt_reg  [NUM_CH];
   logic [15:0] cnt_next [NUM_CH];

   logic [1:0]  a_stg;
   logic [3:0]  a_ch;
   logic        any_once;
   cgo_word_t   mean [NUM_CH];
   logic        conv [NUM_CH];

   assign a_stg = amp_sel_reg[5:4];
   assign a_ch  = amp_sel_reg[3:0];

   // Per-channel frame mean of the incoming pixels, used by the auto loops
   always_comb begin
      for (int c = 0; c < NUM_CH; c++) begin
         acc_next[c] = acc_reg[c];
         cnt_next[c] = cnt_reg[c];
         mean[c]     = (cnt_reg[c] == 16'h0000) ? 16'h0000
                       : 16'(acc_reg[c] / {16'h0000, cnt_reg[c]});
         conv[c]     = (mean[c] > target_reg) ? ((mean[c] - target_reg) <= CONV_TOL)
                       : ((target_reg - mean[c]) <= CONV_TOL);
         if (i_frame_end) begin
            acc_next[c] = '0;
            cnt_next[c] = '0;
         end else if (i_pix_valid && i_pix_channel == 4'(c) && cnt_reg[c] != 16'hFFFF) begin
            acc_next[c] = acc_reg[c] + {{(32-PIX_W){1'b0}}, i_pix_data};
            cnt_next[c] = cnt_reg[c] + 16'h0001;
         end
      end
   end

   // Settings, auto modes and register bus
   always_comb begin
      amp_next     = amp_reg;
      ofs_next     = ofs_reg;
      amp_auto_next = amp_auto_reg;
      ofs_auto_next = ofs_auto_reg;
      amp_sel_next = amp_sel_reg;
      ofs_sel_next = ofs_sel_reg;
      amp_tm_next  = amp_tm_reg;
      ofs_tm_next  = ofs_tm_reg;
      target_next  = target_reg;
      frames_next  = frames_reg;
      rdata_next   = rdata_reg;
      wait_next    = 1'b1;
      any_once     = 1'b0;
      // Status shows a Once run in progress on any per-channel entry
      for (int c = 1; c < NUM_CH; c++) begin
         if (ofs_auto_reg[c] == MODE_ONCE || amp_auto_reg[SEL_STG_PLAIN][c] == MODE_ONCE
             || amp_auto_reg[SEL_STG_ANALOG][c] == MODE_ONCE
             || amp_auto_reg[SEL_STG_DIGITAL][c] == MODE_ONCE) begin
            any_once = 1'b1;
         end
      end

      // Frame-end auto step: only per-channel settings, common stage stays user set
      if (i_frame_end) begin
         for (int s = 0; s < 3; s++) begin
            for (int c = 1; c < NUM_CH; c++) begin
               if (amp_auto_reg[s][c] == MODE_ONCE || amp_auto_reg[s][c] == MODE_CONTINUOUS) begin
                  if (!conv[c] && mean[c] < target_reg && amp_reg[s][c] < 16'hFFFB) begin
                     amp_next[s][c] = amp_reg[s][c] + AMP_STEP;
                  end else if (!conv[c] && mean[c] > target_reg && amp_reg[s][c] > AMP_STEP) begin
                     amp_next[s][c] = amp_reg[s][c] - AMP_STEP;
                  end
                  if (amp_auto_reg[s][c] == MODE_ONCE) begin
                     any_once = 1'b1;
                     if (conv[c] || frames_reg == ONCE_MAX_FRAMES) begin
                        amp_auto_next[s][c] = MODE_OFF;
                     end
                  end
               end
            end
         end
         for (int c = 1; c < NUM_CH; c++) begin
            if (ofs_auto_reg[c] == MODE_ONCE || ofs_auto_reg[c] == MODE_CONTINUOUS) begin
               if (!conv[c] && mean[c] < target_reg) begin
                  ofs_next[c] = ofs_reg[c] + OFS_STEP;
               end else if (!conv[c] && mean[c] > target_reg) begin
                  ofs_next[c] = ofs_reg[c] - OFS_STEP;
               end
               if (ofs_auto_reg[c] == MODE_ONCE) begin
                  any_once = 1'b1;
                  if (conv[c] || frames_reg == ONCE_MAX_FRAMES) begin
                     ofs_auto_next[c] = MODE_OFF;
                  end
               end
            end
         end
         // Tap match: every per-channel entry takes the reference (red) channel setting
         if (amp_tm_reg == MODE_ONCE || amp_tm_reg == MODE_CONTINUOUS) begin
            for (int s = 0; s < 3; s++) begin
               for (int c = 2; c < NUM_CH; c++) begin
                  amp_next[s][c] = amp_next[s][1];
               end
            end
            if (amp_tm_reg == MODE_ONCE) begin
               amp_tm_next = MODE_OFF;
            end
         end
         if (ofs_tm_reg == MODE_ONCE || ofs_tm_reg == MODE_CONTINUOUS) begin
            for (int c = 2; c < NUM_CH; c++) begin
               ofs_next[c] = ofs_next[1];
            end
            if (ofs_tm_reg == MODE_ONCE) begin
               ofs_tm_next = MODE_OFF;
            end
         end
         frames_next = any_once ? frames_reg + 8'h01 : 8'h00;
      end

      if ((i_read || i_write) && wait_reg) begin
         wait_next = 1'b0;
      end
      if (i_write && !wait_reg) begin
         if (i_address == REG_AMP_SEL) begin
            amp_sel_next = i_writedata[5:0];
         end else if (i_address == REG_AMP_VALUE) begin
            amp_next[a_stg][a_ch] = i_writedata[15:0];
         end else if (i_address == REG_AMP_AUTO) begin
            amp_auto_next[a_stg][a_ch] = cgo_clip_mode(i_writedata);
         end else if (i_address == REG_AMP_TAP_MATCH) begin
            amp_tm_next = cgo_clip_mode(i_writedata);
         end else if (i_address == REG_OFS_SEL) begin
            ofs_sel_next = i_writedata[3:0];
         end else if (i_address == REG_OFS_VALUE) begin
            ofs_next[ofs_sel_reg] = i_writedata[15:0];
         end else if (i_address == REG_OFS_AUTO) begin
            ofs_auto_next[ofs_sel_reg] = cgo_clip_mode(i_writedata);
         end else if (i_address == REG_OFS_TAP_MATCH) begin
            ofs_tm_next = cgo_clip_mode(i_writedata);
         end else if (i_address == REG_TARGET_LEVEL) begin
            target_next = i_writedata[15:0];
         end
      end
      if (i_read && wait_reg) begin
         // Reads show the setting currently applied, auto-adjusted or not
         if (i_address == REG_AMP_SEL) begin
            rdata_next = {26'h0, amp_sel_reg};
         end else if (i_address == REG_AMP_VALUE && a_stg != 2'h3 && a_ch < 4'(NUM_CH)) begin
            rdata_next = {16'h0000, amp_reg[a_stg][a_ch]};
         end else if (i_address == REG_AMP_AUTO && a_stg != 2'h3 && a_ch < 4'(NUM_CH)) begin
            rdata_next = {30'h0, amp_auto_reg[a_stg][a_ch]};
         end else if (i_address == REG_AMP_TAP_MATCH) begin
            rdata_next = {30'h0, amp_tm_reg};
         end else if (i_address == REG_OFS_SEL) begin
            rdata_next = {28'h0, ofs_sel_reg};
         end else if (i_address == REG_OFS_VALUE && ofs_sel_reg < 4'(NUM_CH)) begin
            rdata_next = {16'h0000, ofs_reg[ofs_sel_reg]};
         end else if (i_address == REG_OFS_AUTO && ofs_sel_reg < 4'(NUM_CH)) begin
            rdata_next = {30'h0, ofs_auto_reg[ofs_sel_reg]};
         end else if (i_address == REG_OFS_TAP_MATCH) begin
            rdata_next = {30'h0, ofs_tm_reg};
         end else if (i_address == REG_TARGET_LEVEL) begin
            rdata_next = {16'h0000, target_reg};
         end else if (i_address == REG_STATUS) begin
            rdata_next = {23'h0, any_once, frames_reg};
         end else begin
            rdata_next = 32'h00000000;
         end
      end
   end

   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         for (int c = 0; c < NUM_CH; c++) begin
            for (int s = 0; s < 3; s++) begin
               amp_reg[s][c]      <= AMP_UNITY;
               amp_auto_reg[s][c] <= MODE_OFF;
            end
            ofs_reg[c]      <= OFS_ZERO;
            ofs_auto_reg[c] <= MODE_OFF;
            acc_reg[c]      <= '0;
            cnt_reg[c]      <= '0;
         end
         amp_sel_reg <= '0;
         ofs_sel_reg <= SEL_CH_ALL;
         amp_tm_reg  <= MODE_OFF;
         ofs_tm_reg  <= MODE_OFF;
         target_reg  <= TARGET_RST;
         frames_reg  <= '0;
         rdata_reg   <= '0;
         wait_reg    <= 1'b1;
      end else begin
         amp_reg      <= amp_next;
         amp_auto_reg <= amp_auto_next;
         ofs_reg      <= ofs_next;
         ofs_auto_reg <= ofs_auto_next;
         acc_reg      <= acc_next;
         cnt_reg      <= cnt_next;
         amp_sel_reg  <= amp_sel_next;
         ofs_sel_reg  <= ofs_sel_next;
         amp_tm_reg   <= amp_tm_next;
         ofs_tm_reg   <= ofs_tm_next;
         target_reg   <= target_next;
         frames_reg   <= frames_next;
         rdata_reg    <= rdata_next;
         wait_reg     <= wait_next;
      end
   end

   assign o_readdata    = rdata_reg;
   assign o_waitrequest = wait_reg;

   // Effective per-pixel factors: common x analog x digital x per-channel stages
   logic [3:0]  pch;
   logic [15:0] eff_amp;
   logic [15:0] eff_ofs;
   logic [31:0] p1, p2, p3, p4, p5, p6;

   always_comb begin
      pch = (i_pix_channel < 4'(NUM_CH) && i_pix_channel != SEL_CH_ALL) ? i_pix_channel
            : SEL_CH_RED;
      p1  = amp_reg[SEL_STG_PLAIN][SEL_CH_ALL] * amp_reg[SEL_STG_PLAIN][pch];
      p2  = amp_reg[SEL_STG_ANALOG][SEL_CH_ALL] * amp_reg[SEL_STG_ANALOG][pch];
      p3  = amp_reg[SEL_STG_DIGITAL][SEL_CH_ALL] * amp_reg[SEL_STG_DIGITAL][pch];
      p4  = p1[23:8] * p2[23:8];
      p5  = p4[23:8] * p3[23:8];
      p6  = p5;
      eff_amp = (p6[31:24] != 8'h00) ? 16'hFFFF : p6[23:8];
      eff_ofs = ofs_reg[SEL_CH_ALL] + ofs_reg[pch];
   end

   cgo_pixel_stage #(
      .PIX_W (PIX_W)
   ) u_pixel_stage (
      .i_clock  (i_clock),
      .i_rst_n  (i_rst_n),
      .i_valid  (i_pix_valid),
      .i_pixel  (i_pix_data),
      .i_offset (eff_ofs),
      .i_amp    (eff_amp),
      .o_valid  (o_pix_valid),
      .o_pixel  (o_pix_data)
   );
endmodule
`default_nettype wire

// file: cgo_channel_control_props.sv
// Checker for bus handshake, read-back widths and pixel timing.
// Assumes it is bound onto cgo_channel_control and sees only its ports.
`timescale 1ns/100ps
`default_nettype none
module cgo_channel_control_props (
   input wire logic        i_clock,
   input wire logic        i_rst_n,
   input wire logic [5:0]  i_address,
   input wire logic        i_read,
   input wire logic        i_write,
   input wire logic [31:0] o_readdata,
   input wire logic        o_waitrequest,
   input wire logic        i_pix_valid,
   input wire logic        o_pix_valid
);
   default clocking cb @(posedge i_clock);
   endclocking
   default disable iff (!i_rst_n);
   sequence s_req;
      (i_read || i_write) && o_waitrequest;
   endsequence
   sequence s_rd;
      i_read && o_waitrequest;
   endsequence
   chk_one_wait: assert property (s_req |=> !o_waitrequest)
      else $error("access not answered after one wait state");
   chk_wait_pulse: assert property (!o_waitrequest |=> o_waitrequest)
      else $error("wait release longer than one cycle");
   chk_idle_wait: assert property (!(i_read || i_write) |=> o_waitrequest)
      else $error("wait release without request");
   chk_read_hold: assert property (!(i_read && o_waitrequest) |=> $stable(o_readdata))
      else $error("read data changed without read");
   chk_mode_width: assert property (s_rd ##0 (i_address inside {6'h08, 6'h0C, 6'h18, 6'h1C})
      |=> o_readdata[31:2] == 30'h0)
      else $error("mode read wider than two bits");
   chk_sel_width: assert property (s_rd ##0 (i_address inside {6'h00, 6'h10})
      |=> o_readdata[31:6] == 26'h0)
      else $error("selector read wider than six bits");
   chk_value_width: assert property (s_rd ##0 (i_address inside {6'h04, 6'h20})
      |=> o_readdata[31:16] == 16'h0)
      else $error("value read wider than sixteen bits");
   chk_pix_latency: assert property (i_pix_valid |-> ##2 o_pix_valid)
      else $error("pixel output not two cycles after input");
   chk_pix_quiet: assert property (!i_pix_valid |-> ##2 !o_pix_valid)
      else $error("pixel output without input");
endmodule
bind cgo_channel_control cgo_channel_control_props props_inst (
   .i_clock      (i_clock),
   .i_rst_n      (i_rst_n),
   .i_address    (i_address),
   .i_read       (i_read),
   .i_write      (i_write),
   .o_readdata   (o_readdata),
   .o_waitrequest(o_waitrequest),
   .i_pix_valid  (i_pix_valid),
   .o_pix_valid  (o_pix_valid)
);
`default_nettype wire

// file: cgo_sensor_model.sv
// Sensor side model: sends tagged pixels, then a frame-end pulse.
// Assumes the caller enters its task just after a rising clock edge.
`timescale 1ns/100ps
`default_nettype none
module cgo_sensor_model (
   input  wire logic  i_clock,
   output logic       o_valid,
   output logic [3:0] o_channel,
   output logic [11:0] o_data,
   output logic       o_frame_end
);
   initial begin
      o_valid = 1'b0;
      o_channel = 4'h1;
      o_data = 12'h000;
      o_frame_end = 1'b0;
   end
   task automatic frame(input logic [3:0] ch, input logic [11:0] d, input int n);
      for (int k = 0; k < n; k++) begin
         o_valid <= 1'b1;
         o_channel <= ch;
         o_data <= d;
         @(posedge i_clock);
      end
      // Released data shows the inverse so stale values are not mistaken
      o_valid <= 1'b0;
      o_data <= ~d;
      o_frame_end <= 1'b1;
      @(posedge i_clock);
      o_frame_end <= 1'b0;
   endtask
endmodule
`default_nettype wire

// file: cgo_channel_control_tb.sv
// Self-checking bench: register accesses over Avalon-MM and pixel checks.
// Assumes the sensor model drives the pixel port and frame-end pulse.
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin err_count++; $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module cgo_channel_control_tb;
   import cgo_pkg::*;
   logic        i_clock = 1'b0;
   logic        i_rst_n;
   logic [5:0]  i_address;
   logic        i_read;
   logic        i_write;
   logic [31:0] i_writedata;
   logic [31:0] o_readdata;
   logic        o_waitrequest;
   logic        pix_valid;
   logic [3:0]  pix_channel;
   logic [11:0] pix_data;
   logic        frame_end;
   logic        o_pix_valid;
   logic [11:0] o_pix_data;
   logic [31:0] rd;
   int          err_count = 0;
   int          num_checks = 0;
   logic [5:0]  ra [8] = '{REG_AMP_VALUE, REG_AMP_AUTO, REG_AMP_TAP_MATCH, REG_OFS_VALUE,
                           REG_OFS_AUTO, REG_OFS_TAP_MATCH, REG_TARGET_LEVEL, 6'h28};
   logic [31:0] re [8] = '{{16'h0, AMP_UNITY}, 32'h0, 32'h0, {16'h0, OFS_ZERO},
                           32'h0, 32'h0, {16'h0, TARGET_RST}, 32'h0};
   always #2.5 i_clock = ~i_clock;
   cgo_channel_control cgo_channel_control_inst (
      .i_clock(i_clock), .i_rst_n(i_rst_n), .i_address(i_address), .i_read(i_read),
      .i_write(i_write), .i_writedata(i_writedata), .o_readdata(o_readdata),
      .o_waitrequest(o_waitrequest), .i_pix_valid(pix_valid), .i_pix_channel(pix_channel),
      .i_pix_data(pix_data), .i_frame_end(frame_end), .o_pix_valid(o_pix_valid),
      .o_pix_data(o_pix_data));
   cgo_sensor_model sensor_inst (
      .i_clock(i_clock), .o_valid(pix_valid), .o_channel(pix_channel),
      .o_data(pix_data), .o_frame_end(frame_end));
   task automatic final_report();
      if (err_count == 0 && num_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic xfer(input logic rnw, input logic [5:0] a, input logic [31:0] wd);
      i_read <= rnw;
      i_write <= !rnw;
      i_address <= a;
      i_writedata <= wd;
      do @(posedge i_clock); while (o_waitrequest !== 1'b0);
      rd = o_readdata;
      i_read <= 1'b0;
      i_write <= 1'b0;
      @(posedge i_clock);
   endtask
   task automatic wr(input logic [5:0] a, input logic [31:0] wd);
      xfer(1'b0, a, wd);
   endtask
   task automatic chk_rd(input logic [5:0] a, input logic [31:0] e);
      xfer(1'b1, a, 32'h0);
      `CHK(rd, e)
   endtask
   task automatic chk_pix(input logic [3:0] ch, input logic [11:0] d, input logic [11:0] e);
      sensor_inst.frame(ch, d, 1);
      // Output stands for one cycle after the frame-end edge; look mid-cycle
      @(negedge i_clock);
      `CHK(o_pix_valid, 1'b1)
      `CHK(o_pix_data, e)
      @(posedge i_clock);
   endtask
   task automatic frames(input int n);
      repeat (n) sensor_inst.frame(SEL_CH_RED, 12'h000, 1);
   endtask
   initial begin
      repeat (5000) @(posedge i_clock);
      err_count++;
      final_report();
   end
   initial begin
      i_rst_n = 1'b0;
      i_read = 1'b0;
      i_write = 1'b0;
      i_address = 6'h00;
      i_writedata = 32'h0;
      repeat (4) @(posedge i_clock);
      i_rst_n <= 1'b1;
      for (int k = 0; k < 8; k++) chk_rd(ra[k], re[k]);
      // Common offset stage is separate from the per-channel entries
      wr(REG_OFS_SEL, 32'h00);
      wr(REG_OFS_VALUE, 32'h0010);
      wr(REG_OFS_SEL, 32'h01);
      wr(REG_OFS_VALUE, 32'h0005);
      wr(REG_OFS_SEL, 32'h00);
      chk_rd(REG_OFS_VALUE, 32'h0010);
      wr(REG_OFS_SEL, 32'h01);
      wr(REG_AMP_SEL, 32'h01);
      wr(REG_AMP_VALUE, 32'h0200);
      chk_pix(SEL_CH_RED, 12'h100, 12'h22A);
      chk_pix(SEL_CH_GREEN, 12'h100, 12'h110);
      wr(REG_AMP_SEL, 32'h12);
      wr(REG_AMP_VALUE, 32'h0200);
      wr(REG_AMP_SEL, 32'h02);
      chk_rd(REG_AMP_VALUE, 32'h0100);
      wr(REG_AMP_SEL, 32'h22);
      chk_rd(REG_AMP_VALUE, 32'h0100);
      chk_pix(SEL_CH_GREEN, 12'h100, 12'h220);
      wr(REG_AMP_SEL, 32'h00);
      wr(REG_AMP_VALUE, 32'h0200);
      chk_pix(SEL_CH_BLUE, 12'h100, 12'h220);
      chk_pix(SEL_CH_TAP2, 12'h100, 12'h220);
      wr(REG_AMP_VALUE, 32'h0100);
      // Dark frames keep the auto loop stepping upward
      wr(REG_AMP_SEL, 32'h01);
      wr(REG_AMP_AUTO, 32'(MODE_CONTINUOUS));
      frames(3);
      chk_rd(REG_AMP_VALUE, 32'h020C);
      chk_rd(REG_AMP_AUTO, 32'(MODE_CONTINUOUS));
      wr(REG_AMP_AUTO, 32'(MODE_OFF));
      wr(REG_AMP_VALUE, 32'h0300);
      frames(1);
      chk_rd(REG_AMP_VALUE, 32'h0300);
      wr(REG_AMP_AUTO, 32'(MODE_HOLD));
      frames(1);
      chk_rd(REG_AMP_AUTO, 32'(MODE_HOLD));
      chk_rd(REG_AMP_VALUE, 32'h0300);
      wr(REG_AMP_AUTO, 32'(MODE_ONCE));
      frames(64);
      chk_rd(REG_AMP_AUTO, 32'(MODE_ONCE));
      chk_rd(REG_STATUS, {23'h0, 1'b1, ONCE_MAX_FRAMES});
      frames(1);
      chk_rd(REG_AMP_AUTO, 32'(MODE_OFF));
      wr(REG_AMP_VALUE, 32'h0180);
      wr(REG_AMP_TAP_MATCH, 32'(MODE_ONCE));
      frames(1);
      chk_rd(REG_AMP_TAP_MATCH, 32'(MODE_OFF));
      wr(REG_AMP_SEL, 32'h02);
      chk_rd(REG_AMP_VALUE, 32'h0180);
      wr(REG_OFS_TAP_MATCH, 32'(MODE_ONCE));
      frames(1);
      chk_rd(REG_OFS_TAP_MATCH, 32'(MODE_OFF));
      wr(REG_OFS_SEL, 32'h02);
      chk_rd(REG_OFS_VALUE, 32'h0005);
      wr(REG_OFS_SEL, 32'h01);
      wr(REG_OFS_AUTO, 32'(MODE_CONTINUOUS));
      frames(2);
      chk_rd(REG_OFS_VALUE, 32'h0007);
      wr(REG_OFS_AUTO, 32'(MODE_ONCE));
      frames(65);
      chk_rd(REG_OFS_AUTO, 32'(MODE_OFF));
      chk_rd(REG_OFS_VALUE, 32'h0048);
      final_report();
   end
endmodule
`default_nettype wire
